// *** include/adcseq_pkg.sv ***
// Summary of operation
// - Converter runs only while enable bit set
// - Writing go while enabled starts conversion
// - Completion clears go, flags done, loads result
// - Early go clear stores partial, extended result
// - Reset clears registers, stops any conversion
// - Sleep conversion only with dedicated RC clock
// - RC clock delays start one instruction cycle
// - Sleep completion with interrupt enabled wakes
// - Sleep completion, interrupt off: power down
// - Other clock: sleep aborts, powers down
// - Compare trigger while enabled sets go, clears timer
package adcseq_pkg;
    // ==================================================
    // Register offsets
    localparam logic [3:0] CTRL0_OFFSET   = 4'h0;
    localparam logic [3:0] CTRL1_OFFSET   = 4'h1;
    localparam logic [3:0] RES_HI_OFFSET  = 4'h2;
    localparam logic [3:0] RES_LO_OFFSET  = 4'h3;
    localparam logic [3:0] STATUS_OFFSET  = 4'h4;
    localparam logic [3:0] MASK_OFFSET    = 4'h5;
    // ==================================================
    // Field positions
    localparam int ON_BIT       = 0;
    localparam int GO_BIT       = 1;
    localparam int CLKSEL_BIT   = 0;
    localparam int DONE_BIT     = 0;
    localparam int ABORT_BIT    = 1;
    // ==================================================
    // Reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    // ==================================================
    // Timing
    localparam int RESULT_BITS     = 10;
    localparam int BIT_CYCLES      = 4;
    localparam int INSTR_TIME_NS   = 16;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int INSTR_CYCLES    = INSTR_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_CNT_MAX   = 4'(BIT_CYCLES - 1);
    localparam logic [3:0] INSTR_CNT_MAX = 4'(INSTR_CYCLES - 1);
    typedef enum logic [1:0] {
        ADCSEQ_IDLE,
        ADCSEQ_DELAY,
        ADCSEQ_CONV
    } adcseq_state_type;
endpackage

// *** rtl/adcseq_sar.sv ***
// SAR approximation register; partial results extend the last resolved bit
module adcseq_sar (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clear,
    input  wire logic        step,
    input  wire logic        comp_in,
    output logic [9:0]       sar_reg,
    output logic [3:0]       idx_reg
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sar_reg <= 10'h000;
            idx_reg <= 4'h0;
        end else if (clear) begin
            sar_reg <= 10'h000;
            idx_reg <= 4'h0;
        end else if (step && idx_reg < 4'hA) begin
            sar_reg[4'(9) - idx_reg] <= comp_in;
            idx_reg <= idx_reg + 4'h1;
        end
    end
endmodule // adcseq_sar

// *** rtl/adcseq_fill.sv ***
// Combinational fill of unresolved bits with the last resolved bit
module adcseq_fill (
    input  wire logic [9:0]  sar,
    input  wire logic [3:0]  idx,
    output logic [9:0]       filled
);
    always_comb begin
        filled = sar;
        for (int i = 0; i < 10; i++) begin
            if (idx != 4'h0 && (9 - i) >= int'(idx))
                filled[i] = sar[4'(10) - idx];
        end
    end
endmodule // adcseq_fill

// *** rtl/adcseq_top.sv ***
module adcseq_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    input  wire logic        comp_in,
    input  wire logic        compare_unit_four_trigger,
    input  wire logic        sleep_req,
    output logic             timer_clear,
    output logic             wake,
    output logic             analog_powered,
    output logic             irq
);
    // ==================================================
    // State and registers
    adcseq_pkg::adcseq_state_type state_reg;
    logic        converter_on_reg;
    logic        go_reg;
    logic        rc_clk_sel_reg;
    logic [7:0]  result_high_byte_reg;
    logic [7:0]  result_low_byte_reg;
    logic        conversion_done_flag_reg;
    logic        abort_flag_reg;
    logic [1:0]  mask_reg;
    logic [3:0]  cnt_reg;
    logic        powered_down_reg;
    logic [7:0]  rdata_reg;
    logic [9:0]  sar;
    logic [3:0]  idx;
    logic [9:0]  filled;
    logic        ctrl_wr;
    logic        sw_go;
    logic        sw_stop;
    logic        step;
    logic        finish;
    logic        abort_now;
    logic        sar_clear;
    logic        stat_rd;
    logic        done_set;
    logic        abort_set;

    assign ctrl_wr  = wr && addr == adcseq_pkg::CTRL0_OFFSET;
    assign stat_rd  = rd && addr == adcseq_pkg::STATUS_OFFSET;
    // Go only honoured while the converter is on
    assign sw_go    = ctrl_wr && wdata[adcseq_pkg::GO_BIT] && wdata[adcseq_pkg::ON_BIT]
                      && converter_on_reg;
    assign sw_stop  = ctrl_wr && !wdata[adcseq_pkg::GO_BIT] && go_reg;
    // Without the RC clock, sleep kills the conversion
    // A start still pending when sleep comes is dropped as well
    assign abort_now = sleep_req && !rc_clk_sel_reg && go_reg;
    assign step     = state_reg == adcseq_pkg::ADCSEQ_CONV && cnt_reg == adcseq_pkg::BIT_CNT_MAX;
    assign finish   = step && idx == 4'(adcseq_pkg::RESULT_BITS - 1);
    assign sar_clear = state_reg == adcseq_pkg::ADCSEQ_IDLE;
    assign done_set = finish || (sw_stop && state_reg == adcseq_pkg::ADCSEQ_CONV);

    assign abort_set = abort_now;

    adcseq_sar u_sar (
        .clk     (clk),
        .arst_n  (arst_n),
        .clear   (sar_clear),
        .step    (step),
        .comp_in (comp_in),
        .sar_reg (sar),
        .idx_reg (idx)
    );

    adcseq_fill u_fill (
        .sar    (sar),
        .idx    (idx),
        .filled (filled)
    );

    // ==================================================
    // Control register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            converter_on_reg <= adcseq_pkg::CTRL_RESET[adcseq_pkg::ON_BIT];
            rc_clk_sel_reg   <= adcseq_pkg::CTRL_RESET[adcseq_pkg::CLKSEL_BIT];
        end else begin
            if (ctrl_wr)
                converter_on_reg <= wdata[adcseq_pkg::ON_BIT];
            if (wr && addr == adcseq_pkg::CTRL1_OFFSET)
                rc_clk_sel_reg <= wdata[adcseq_pkg::CLKSEL_BIT];
        end
    end

    // ==================================================
    // Go flag: hardware start, software stop, hardware clear on end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            go_reg <= 1'b0;
        end else if (finish || abort_now || (ctrl_wr && !wdata[adcseq_pkg::ON_BIT])) begin
            go_reg <= 1'b0;
        end else if (compare_unit_four_trigger && converter_on_reg) begin
            go_reg <= 1'b1;
        end else if (ctrl_wr) begin
            go_reg <= sw_go;
        end
    end

    // Timer restarts together with the triggered start
    assign timer_clear = compare_unit_four_trigger && converter_on_reg;

    // ==================================================
    // Sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= adcseq_pkg::ADCSEQ_IDLE;
            cnt_reg   <= 4'h0;
        end else begin
            case (state_reg)
                adcseq_pkg::ADCSEQ_IDLE: begin
                    cnt_reg <= 4'h0;
                    if (go_reg && !powered_down_reg) begin
                        // Extra instruction lets a sleep instruction run first
                        state_reg <= rc_clk_sel_reg ? adcseq_pkg::ADCSEQ_DELAY
                                                    : adcseq_pkg::ADCSEQ_CONV;
                    end
                end
                adcseq_pkg::ADCSEQ_DELAY: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (!go_reg || abort_now) begin
                        state_reg <= adcseq_pkg::ADCSEQ_IDLE;
                    end else if (cnt_reg == adcseq_pkg::INSTR_CNT_MAX) begin
                        state_reg <= adcseq_pkg::ADCSEQ_CONV;
                        cnt_reg   <= 4'h0;
                    end
                end
                adcseq_pkg::ADCSEQ_CONV: begin
                    cnt_reg <= (cnt_reg == adcseq_pkg::BIT_CNT_MAX) ? 4'h0 : cnt_reg + 4'h1;
                    if (finish || !go_reg || abort_now)
                        state_reg <= adcseq_pkg::ADCSEQ_IDLE;
                end
                default: state_reg <= adcseq_pkg::ADCSEQ_IDLE;
            endcase
        end
    end

    // ==================================================
    // Result bytes, right justified
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_high_byte_reg <= 8'h00;
            result_low_byte_reg  <= 8'h00;
        end else if (finish) begin
            result_high_byte_reg <= {6'h00, sar[9:8]};
            result_low_byte_reg  <= {sar[7:1], comp_in};
        end else if (done_set) begin
            result_high_byte_reg <= {6'h00, filled[9:8]};
            result_low_byte_reg  <= filled[7:0];
        end
    end

    // ==================================================
    // Sleep power handling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            powered_down_reg <= 1'b0;
        end else if (!sleep_req) begin
            powered_down_reg <= 1'b0;
        end else if (!rc_clk_sel_reg) begin
            // Without the RC clock the analog side goes dark on entering sleep
            powered_down_reg <= 1'b1;
        end else if (!converter_on_reg) begin
            powered_down_reg <= 1'b0;
        end else if (finish && !mask_reg[adcseq_pkg::DONE_BIT]) begin
            // Enable bit keeps reading set while analog side is off
            powered_down_reg <= 1'b1;
        end
    end

    assign analog_powered = converter_on_reg && !powered_down_reg;
    assign wake = sleep_req && conversion_done_flag_reg && mask_reg[adcseq_pkg::DONE_BIT];

    // ==================================================
    // Sticky status, cleared by reading; set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_done_flag_reg <= 1'b0;
            abort_flag_reg           <= 1'b0;
        end else begin
            conversion_done_flag_reg <= done_set || (conversion_done_flag_reg && !stat_rd);
            abort_flag_reg           <= abort_set || (abort_flag_reg && !stat_rd);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            mask_reg <= adcseq_pkg::MASK_RESET[1:0];
        else if (wr && addr == adcseq_pkg::MASK_OFFSET)
            mask_reg <= wdata[1:0];
    end

    assign irq = |({abort_flag_reg, conversion_done_flag_reg} & mask_reg);

    // ==================================================
    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            case (addr)
                adcseq_pkg::CTRL0_OFFSET:  rdata_reg <= {6'h00, go_reg, converter_on_reg};
                adcseq_pkg::CTRL1_OFFSET:  rdata_reg <= {7'h00, rc_clk_sel_reg};
                adcseq_pkg::RES_HI_OFFSET: rdata_reg <= result_high_byte_reg;
                adcseq_pkg::RES_LO_OFFSET: rdata_reg <= result_low_byte_reg;
                adcseq_pkg::STATUS_OFFSET: rdata_reg <= {6'h00, abort_flag_reg,
                                                         conversion_done_flag_reg};
                adcseq_pkg::MASK_OFFSET:   rdata_reg <= {6'h00, mask_reg};
                default:                   rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata = rdata_reg;
endmodule // adcseq_top

// *** sim/adcseq_top_sva.sv ***
module adcseq_top_sva (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       compare_unit_four_trigger,
    input wire logic       sleep_req,
    input wire logic       timer_clear,
    input wire logic       wake,
    input wire logic       analog_powered,
    input wire logic       irq
);
    // ==================================================
    // Shadow of the control bits, seen from the write port
    logic on_q;
    logic rc_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) on_q <= 1'b0;
        else if (wr && addr == adcseq_pkg::CTRL0_OFFSET) on_q <= wdata[adcseq_pkg::ON_BIT];
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rc_q <= 1'b0;
        else if (wr && addr == adcseq_pkg::CTRL1_OFFSET) rc_q <= wdata[adcseq_pkg::CLKSEL_BIT];
    end
    // ==================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_off_write;
        wr && addr == adcseq_pkg::CTRL0_OFFSET && !wdata[adcseq_pkg::ON_BIT];
    endsequence
    sequence s_trig_on;
        compare_unit_four_trigger && on_q;
    endsequence
    sequence s_cold_sleep;
        sleep_req && !rc_q;
    endsequence
    property p_on_dark; !on_q |-> !analog_powered; endproperty
    property p_off_write; s_off_write |=> !analog_powered; endproperty
    // One cycle allowed, the power-down flag is registered
    property p_sleep_dark;
        s_cold_sleep ##1 s_cold_sleep |-> !analog_powered;
    endproperty
    property p_trig_only; timer_clear |-> compare_unit_four_trigger; endproperty
    property p_trig_on; s_trig_on |-> timer_clear; endproperty
    property p_wake; wake |-> irq && sleep_req; endproperty
    // Only a status read or a mask write may drop the line
    property p_irq_hold;
        irq && !(wr && addr == adcseq_pkg::MASK_OFFSET)
            && !(rd && addr == adcseq_pkg::STATUS_OFFSET) |=> irq;
    endproperty
    property p_rst; $rose(arst_n) |-> !irq && !wake && !analog_powered; endproperty
    a_on_dark: assert property (p_on_dark) else $error("powered while off");
    a_off_write: assert property (p_off_write) else $error("still powered");
    a_sleep_dark: assert property (p_sleep_dark) else $error("awake in sleep");
    a_trig_only: assert property (p_trig_only) else $error("stray clear");
    a_trig_on: assert property (p_trig_on) else $error("no timer clear");
    a_wake: assert property (p_wake) else $error("bad wake");
    a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
    a_rst: assert property (p_rst) else $error("busy after reset");
endmodule // adcseq_top_sva

bind adcseq_top adcseq_top_sva i_adcseq_top_sva (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .compare_unit_four_trigger(compare_unit_four_trigger),
    .sleep_req(sleep_req), .timer_clear(timer_clear), .wake(wake),
    .analog_powered(analog_powered), .irq(irq));

// *** sim/adcseq_partner.sv ***
module adcseq_partner (
    input  wire logic clk,
    output logic      comp_in,
    output logic      trigger,
    output logic      sleep_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        comp_in = 1'b0;
        trigger = 1'b0;
        sleep_req = 1'b0;
    end
    task automatic set_lvl(input logic c, input logic s);
        @(posedge clk);
        comp_in <= c;
        sleep_req <= s;
    endtask
    // Callers space triggers by a whole conversion; nothing here enforces it
    task automatic pulse();
        @(posedge clk);
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
    endtask
endmodule // adcseq_partner

// *** sim/adcseq_test.sv ***
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module adcseq_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, arst_n, wr, rd, comp_in, trig, sleep_req;
    logic       timer_clear, wake, analog_powered, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    int         bad_count, n_tests, k;
    adcseq_top i_adcseq_top (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .comp_in(comp_in),
        .compare_unit_four_trigger(trig), .sleep_req(sleep_req),
        .timer_clear(timer_clear), .wake(wake), .analog_powered(analog_powered), .irq(irq));
    adcseq_partner i_adcseq_partner (.clk(clk), .comp_in(comp_in), .trigger(trig),
        .sleep_req(sleep_req));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata & m, e)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait; a hang ends the run as a failure
    task automatic wait_irq(input int n);
        k = 0;
        while (irq !== 1'b1 && k < n) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (irq !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    initial begin
        arst_n = 1'b0;
        {wr, rd, addr, wdata} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h00);
        chk_rd(adcseq_pkg::MASK_OFFSET, 8'h00);
        chk_rd(4'hF, 8'h00);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h02);
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h00);
        wr_reg(adcseq_pkg::MASK_OFFSET, 8'h01);
        i_adcseq_partner.set_lvl(1'b1, 1'b0);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        wait_irq(100);
        `CHK(k >= 40 && k <= 47, 1'b1)
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        chk_rd(adcseq_pkg::RES_HI_OFFSET, 8'h03);
        chk_rd(adcseq_pkg::RES_LO_OFFSET, 8'hFF);
        chk_rd(adcseq_pkg::STATUS_OFFSET, 8'h01, 8'h01);
        chk_rd(adcseq_pkg::STATUS_OFFSET, 8'h00, 8'h01);
        wr_reg(adcseq_pkg::CTRL1_OFFSET, 8'h01);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        i_adcseq_partner.set_lvl(1'b0, 1'b1);
        wait_irq(100);
        `CHK(k >= 43 && k <= 47, 1'b1)
        `CHK(wake, 1'b1)
        chk_rd(adcseq_pkg::RES_LO_OFFSET, 8'h00);
        chk_rd(adcseq_pkg::STATUS_OFFSET, 8'h01, 8'h01);
        wr_reg(adcseq_pkg::MASK_OFFSET, 8'h00);
        i_adcseq_partner.set_lvl(1'b0, 1'b0);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        i_adcseq_partner.set_lvl(1'b0, 1'b1);
        repeat (80) @(posedge clk);
        `CHK(analog_powered, 1'b0)
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        i_adcseq_partner.set_lvl(1'b0, 1'b0);
        wr_reg(adcseq_pkg::CTRL1_OFFSET, 8'h00);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        i_adcseq_partner.set_lvl(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        `CHK(analog_powered, 1'b0)
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h01, 8'h01);
        chk_rd(adcseq_pkg::STATUS_OFFSET, 8'h02, 8'h02);
        i_adcseq_partner.set_lvl(1'b0, 1'b0);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h00);
        wr_reg(adcseq_pkg::MASK_OFFSET, 8'h01);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        // Two zeros resolved, then ones; the go clear lands mid-word
        repeat (9) @(posedge clk);
        i_adcseq_partner.set_lvl(1'b1, 1'b0);
        repeat (12) @(posedge clk);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        wait_irq(10);
        chk_rd(adcseq_pkg::RES_HI_OFFSET, 8'h00);
        chk_rd(adcseq_pkg::RES_LO_OFFSET, 8'hFF);
        chk_rd(adcseq_pkg::STATUS_OFFSET, 8'h01, 8'h01);
        i_adcseq_partner.pulse();
        wait_irq(100);
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h01);
        wr_reg(adcseq_pkg::CTRL0_OFFSET, 8'h03);
        repeat (10) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        chk_rd(adcseq_pkg::CTRL0_OFFSET, 8'h00);
        `CHK(analog_powered, 1'b0)
        end_of_test();
    end
endmodule // adcseq_test
